// file: rtl/card_window_enable_io_control.sv
// How it works
// (RULE_01) No host memory or I/O cycle is claimed through a disabled window.
// (RULE_02) Enable bit 7 turns on I/O window 1, bit 6 window 0; reset off.
// (RULE_03) Enable bits 4 to 0 turn on memory windows 4 to 0; reset off.
// (RULE_04) Enable bit 5 is reserved, reads zero, ignores writes.
// (RULE_05) Control bit 7 adds one ISA wait to 16-bit window 1 cycles.
// (RULE_06) Control bit 6 shortens 8-bit window 1 cycles to three ISA cycles.
// (RULE_07) Control bit 5 makes window 1 width follow the card's 16-bit signal.
// (RULE_08) Control bit 4 picks window 1 fixed width, ignored when bit 5 set.
// (RULE_09) Control bit 3 adds one ISA wait to 16-bit window 0 cycles.
// (RULE_10) Control bit 2 shortens 8-bit window 0 cycles to three ISA cycles.
// (RULE_11) Control bit 1 makes window 0 width follow the card's 16-bit signal.
// (RULE_12) Control bit 0 picks window 0 fixed width, ignored when bit 1 set.
// (RULE_13) Start low byte per window, read/write, low half of start, reset zero.
// (RULE_14) Start high byte per window, read/write, high half of start, reset zero.
// (RULE_15) End low and high bytes per window form the end address, reset zero.
// (RULE_16) An enabled I/O window claims addresses from start to end inclusive.
`timescale 1ns/100ps
module card_window_enable_io_control #(
  parameter int IO_WINDOWS = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic io_req,
  input wire logic [15:0] io_addr,
  input wire logic card_iois16,
  output logic io_claim,
  output logic io_window,
  output logic io_wide,
  output logic io_busy,
  output logic io_done,
  input wire logic mem_req,
  input wire logic [card_window_pkg::MEM_WINDOWS-1:0] mem_hit,
  output logic [card_window_pkg::MEM_WINDOWS-1:0] mem_claim
);

  localparam int LW = card_window_pkg::LEN_W;
  localparam int CW = card_window_pkg::IO_CTRL_FIELD_W;

  logic [7:0] window_enable;
  logic [7:0] io_window_control;
  logic [15:0] io_start [IO_WINDOWS];
  logic [15:0] io_end [IO_WINDOWS];
  logic [IO_WINDOWS-1:0] io_hit;
  logic [IO_WINDOWS-1:0] win_wide;
  logic [LW-1:0] win_len [IO_WINDOWS];
  logic iois16_meta;
  logic iois16_sync;
  card_window_pkg::io_state_t io_state;
  logic timer_start;
  logic [LW-1:0] timer_len;
  logic pick;
  logic take;

  // Card pin crosses in from outside the clock domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      iois16_meta <= 1'b0;
      iois16_sync <= 1'b0;
    end else begin
      iois16_meta <= card_iois16;
      iois16_sync <= iois16_meta;
    end
  end

  // Enable register; bit 5 never stores anything so it always reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      window_enable <= card_window_pkg::WINDOW_ENABLE_RESET; // RULE_02 RULE_03
    end else if (reg_wr && reg_addr == card_window_pkg::OFF_WINDOW_ENABLE) begin
      window_enable <= reg_wdata & card_window_pkg::WINDOW_ENABLE_WRITE_MASK; // RULE_04
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_window_control <= card_window_pkg::IO_CONTROL_RESET;
    end else if (reg_wr && reg_addr == card_window_pkg::OFF_IO_CONTROL) begin
      io_window_control <= reg_wdata;
    end
  end

  genvar i;
  generate
    for (i = 0; i < IO_WINDOWS; i++) begin : g_io
      localparam logic [7:0] SHIFT = 8'(i) * card_window_pkg::IO_WINDOW_STRIDE;
      localparam logic [7:0] A_SL = card_window_pkg::OFF_IO0_START_LOW + SHIFT;
      localparam logic [7:0] A_SH = card_window_pkg::OFF_IO0_START_HIGH + SHIFT;
      localparam logic [7:0] A_EL = card_window_pkg::OFF_IO0_END_LOW + SHIFT;
      localparam logic [7:0] A_EH = card_window_pkg::OFF_IO0_END_HIGH + SHIFT;
      logic [CW-1:0] ctrl;
      logic on;

      assign ctrl = io_window_control[i*CW +: CW];
      assign on = window_enable[card_window_pkg::BIT_IO0_ON + i];

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          io_start[i] <= card_window_pkg::IO_ADDRESS_RESET; // RULE_13 RULE_14
        end else if (reg_wr && reg_addr == A_SL) begin
          io_start[i][7:0] <= reg_wdata; // RULE_13
        end else if (reg_wr && reg_addr == A_SH) begin
          io_start[i][15:8] <= reg_wdata; // RULE_14
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          io_end[i] <= card_window_pkg::IO_ADDRESS_RESET; // RULE_15
        end else if (reg_wr && reg_addr == A_EL) begin
          io_end[i][7:0] <= reg_wdata; // RULE_15
        end else if (reg_wr && reg_addr == A_EH) begin
          io_end[i][15:8] <= reg_wdata; // RULE_15
        end
      end

      // Disabled window never matches, whatever its addresses hold
      assign io_hit[i] = on && io_addr >= io_start[i] && io_addr <= io_end[i]; // RULE_01 RULE_16

      // Card sizing overrides the fixed width bit
      assign win_wide[i] = ctrl[card_window_pkg::BIT_CARD_SIZING] ? iois16_sync : // RULE_07 RULE_11
                           ctrl[card_window_pkg::BIT_FIXED_WIDTH]; // RULE_08 RULE_12

      // Wait bit touches only 16-bit cycles, short bit only 8-bit cycles
      always_comb begin
        if (win_wide[i]) begin
          win_len[i] = card_window_pkg::STD_WIDE_ISA;
          if (ctrl[card_window_pkg::BIT_WIDE_EXTRA_WAIT]) begin
            win_len[i] = card_window_pkg::STD_WIDE_ISA + card_window_pkg::EXTRA_WAIT_ISA; // RULE_05 RULE_09
          end
        end else if (ctrl[card_window_pkg::BIT_NARROW_SHORT]) begin
          win_len[i] = card_window_pkg::SHORT_NARROW_ISA; // RULE_06 RULE_10
        end else begin
          win_len[i] = card_window_pkg::STD_NARROW_ISA;
        end
      end
    end
  endgenerate

  // Window 0 wins where both windows overlap
  assign pick = !io_hit[0];
  assign take = io_req && (io_state == card_window_pkg::IO_IDLE) && (|io_hit); // RULE_01
  assign timer_start = take;
  assign timer_len = win_len[pick];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_state <= card_window_pkg::IO_IDLE;
      io_busy <= 1'b0;
    end else begin
      unique case (io_state)
        card_window_pkg::IO_IDLE: begin
          if (take) begin
            io_state <= card_window_pkg::IO_RUN;
            io_busy <= 1'b1;
          end
        end
        card_window_pkg::IO_RUN: begin
          if (io_done) begin
            io_state <= card_window_pkg::IO_IDLE;
            io_busy <= 1'b0;
          end
        end
      endcase
    end
  end

  // Width is frozen at claim time so a changing card signal cannot tear a cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_claim <= 1'b0;
      io_window <= 1'b0;
      io_wide <= 1'b0;
    end else begin
      io_claim <= take;
      if (take) begin
        io_window <= pick;
        io_wide <= win_wide[pick];
      end
    end
  end

  io_cycle_timer #(
    .LEN_W(LW)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .start(timer_start),
    .isa_cycles(timer_len),
    .done(io_done)
  );

  // Memory decode lives elsewhere; this block only gates it by the enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_claim <= '0;
    end else begin
      mem_claim <= {card_window_pkg::MEM_WINDOWS{mem_req}} & mem_hit &
                   window_enable[card_window_pkg::BIT_MEM0_ON +: card_window_pkg::MEM_WINDOWS]; // RULE_01 RULE_03
    end
  end

  // Read data registered; unmapped offsets read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        card_window_pkg::OFF_WINDOW_ENABLE: reg_rdata <= window_enable; // RULE_04
        card_window_pkg::OFF_IO_CONTROL: reg_rdata <= io_window_control;
        card_window_pkg::OFF_IO0_START_LOW: reg_rdata <= io_start[0][7:0];
        card_window_pkg::OFF_IO0_START_HIGH: reg_rdata <= io_start[0][15:8];
        card_window_pkg::OFF_IO0_END_LOW: reg_rdata <= io_end[0][7:0];
        card_window_pkg::OFF_IO0_END_HIGH: reg_rdata <= io_end[0][15:8];
        card_window_pkg::OFF_IO1_START_LOW: reg_rdata <= io_start[1][7:0];
        card_window_pkg::OFF_IO1_START_HIGH: reg_rdata <= io_start[1][15:8];
        card_window_pkg::OFF_IO1_END_LOW: reg_rdata <= io_end[1][7:0];
        card_window_pkg::OFF_IO1_END_HIGH: reg_rdata <= io_end[1][15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// file: rtl/card_window_pkg.sv
package card_window_pkg;

  // Byte offsets within the socket register space
  localparam logic [7:0] OFF_WINDOW_ENABLE = 8'h06;
  localparam logic [7:0] OFF_IO_CONTROL = 8'h07;
  localparam logic [7:0] OFF_IO0_START_LOW = 8'h08;
  localparam logic [7:0] OFF_IO0_START_HIGH = 8'h09;
  localparam logic [7:0] OFF_IO0_END_LOW = 8'h0A;
  localparam logic [7:0] OFF_IO0_END_HIGH = 8'h0B;
  localparam logic [7:0] OFF_IO1_START_LOW = 8'h0C;
  localparam logic [7:0] OFF_IO1_START_HIGH = 8'h0D;
  localparam logic [7:0] OFF_IO1_END_LOW = 8'h0E;
  localparam logic [7:0] OFF_IO1_END_HIGH = 8'h0F;
  // Window 1 registers sit one stride above window 0
  localparam logic [7:0] IO_WINDOW_STRIDE = 8'h04;

  // Window enable register fields
  localparam int BIT_IO0_ON = 6;
  localparam int BIT_IO1_ON = 7;
  localparam int BIT_RESERVED = 5;
  localparam int BIT_MEM0_ON = 0;
  localparam int MEM_WINDOWS = 5;
  localparam logic [7:0] WINDOW_ENABLE_WRITE_MASK = 8'hDF;

  // I/O control register: one nibble per window, window 0 in the low nibble
  localparam int IO_CTRL_FIELD_W = 4;
  localparam int BIT_FIXED_WIDTH = 0;
  localparam int BIT_CARD_SIZING = 1;
  localparam int BIT_NARROW_SHORT = 2;
  localparam int BIT_WIDE_EXTRA_WAIT = 3;

  // Values after reset
  localparam logic [7:0] WINDOW_ENABLE_RESET = 8'h00;
  localparam logic [7:0] IO_CONTROL_RESET = 8'h00;
  localparam logic [15:0] IO_ADDRESS_RESET = 16'h0000;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int ISA_CYCLE_NS = 125;
  localparam int ISA_CYCLE_CLKS = (ISA_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEN_W = 4;
  localparam logic [3:0] STD_NARROW_ISA = 4'h6;
  localparam logic [3:0] STD_WIDE_ISA = 4'h3;
  localparam logic [3:0] SHORT_NARROW_ISA = 4'h3;
  localparam logic [3:0] EXTRA_WAIT_ISA = 4'h1;

  typedef enum logic {IO_IDLE, IO_RUN} io_state_t;

endpackage

// file: rtl/io_cycle_timer.sv
`timescale 1ns/100ps
module io_cycle_timer #(
  parameter int LEN_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [LEN_W-1:0] isa_cycles,
  output logic done
);

  localparam int DIV_W = $clog2(card_window_pkg::ISA_CYCLE_CLKS + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(card_window_pkg::ISA_CYCLE_CLKS - 1);

  logic [DIV_W-1:0] div;
  logic [LEN_W-1:0] remaining;
  logic running;
  logic isa_tick;

  // One-cycle enable at the ISA cycle rate, phase-aligned to each start
  assign isa_tick = running && (div == DIV_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= '0;
    end else if (start || isa_tick) begin
      div <= '0;
    end else if (running) begin
      div <= div + DIV_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remaining <= '0;
      running <= 1'b0;
    end else if (start) begin
      remaining <= isa_cycles;
      running <= 1'b1;
    end else if (isa_tick) begin
      remaining <= remaining - LEN_W'(1);
      if (remaining == LEN_W'(1)) begin
        running <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= isa_tick && (remaining == LEN_W'(1));
    end
  end

endmodule

// file: tb/card_window_enable_io_control_test.sv
`timescale 1ns/100ps
module card_window_enable_io_control_test;
  logic clk, rst, reg_wr, reg_rd, io_req, mem_req, card_wide;
  logic card_iois16, io_claim, io_window, io_wide, io_busy, io_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] io_addr;
  logic [4:0] mem_hit, mem_claim;
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  logic [7:0] offs [8] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
  // Entry layout: cycles, 2'b00, card width, expected wide, control nibble
  logic [15:0] tab [9] = '{16'h1E00, 16'h0F04, 16'h1E08, 16'h0F11, 16'h0F15, 16'h1419,
    16'h0F32, 16'h1E03, 16'h0F06};
  card_window_enable_io_control card_window_enable_io_control_i (.clk, .rst, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .io_req, .io_addr, .card_iois16, .io_claim,
    .io_window, .io_wide, .io_busy, .io_done, .mem_req, .mem_hit, .mem_claim);
  pc_card_model pc_card_model_i (.clk, .card_wide, .card_iois16);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  task automatic mem_go(input logic [4:0] h, input logic [4:0] e);
    @(posedge clk);
    #1 mem_req = 1'b1;
    mem_hit = h;
    @(posedge clk);
    #1 mem_req = 1'b0;
    chk(mem_claim, e);
  endtask
  task automatic io_go(input logic [15:0] a, input logic c, input logic w, input logic wd,
    input logic [15:0] cyc);
    @(posedge clk);
    #1 io_req = 1'b1;
    io_addr = a;
    @(posedge clk);
    #1 io_req = 1'b0;
    chk(io_claim, c);
    if (c) begin
      chk(io_window, w);
      chk(io_wide, wd);
      n = 0;
      while (io_done !== 1'b1 && n < 100) begin
        @(posedge clk);
        #1 n++;
      end
      chk(16'(n), cyc);
      @(posedge clk);
      #1 chk(io_busy, 1'b0);
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    {rst, reg_wr, reg_rd, io_req, mem_req, card_wide} = 6'h20;
    {reg_addr, reg_wdata, io_addr, mem_hit} = 37'h0;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    foreach (offs[i]) rd(offs[i], 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'hDF);
    for (int i = 8; i < 16; i++) wr(8'(i), 8'h5A ^ 8'(i));
    for (int i = 8; i < 16; i++) rd(8'(i), 8'h5A ^ 8'(i));
    for (int i = 0; i < 2; i++) begin
      wr(8'(8 + 4 * i), 8'h00);
      wr(8'(9 + 4 * i), 8'(1 + i));
      wr(8'(10 + 4 * i), 8'hFF);
      wr(8'(11 + 4 * i), 8'(1 + i));
    end
    wr(8'h06, 8'h00);
    io_go(16'h0150, 1'b0, 1'b0, 1'b0, 16'h0);
    mem_go(5'h1F, 5'h00);
    wr(8'h06, 8'h15);
    mem_go(5'h1F, 5'h15);
    wr(8'h06, 8'h2A);
    mem_go(5'h1B, 5'h0A);
    wr(8'h06, 8'h40);
    io_go(16'h0250, 1'b0, 1'b0, 1'b0, 16'h0);
    io_go(16'h0150, 1'b1, 1'b0, 1'b0, 16'h1E);
    wr(8'h06, 8'hC0);
    for (int w = 0; w < 2; w++) begin
      foreach (tab[k]) begin
        card_wide = tab[k][5];
        wr(8'h07, w ? {tab[k][3:0], 4'h0} : {4'h0, tab[k][3:0]});
        // Let the card level cross the input synchroniser
        repeat (4) @(posedge clk);
        io_go(w ? 16'h0250 : 16'h0150, 1'b1, w[0], tab[k][4], {8'h00, tab[k][15:8]});
      end
    end
    wr(8'h07, 8'h00);
    io_go(16'h01FF, 1'b1, 1'b0, 1'b0, 16'h1E);
    io_go(16'h0200, 1'b1, 1'b1, 1'b0, 16'h1E);
    io_go(16'h00FF, 1'b0, 1'b0, 1'b0, 16'h0);
    io_go(16'h0300, 1'b0, 1'b0, 1'b0, 16'h0);
    tally_and_finish;
  end
endmodule

// file: tb/card_window_properties.sv
`timescale 1ns/100ps
module card_window_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic io_req,
  input wire logic card_iois16,
  input wire logic io_claim,
  input wire logic io_window,
  input wire logic io_wide,
  input wire logic io_busy,
  input wire logic io_done,
  input wire logic mem_req,
  input wire logic [card_window_pkg::MEM_WINDOWS-1:0] mem_hit,
  input wire logic [card_window_pkg::MEM_WINDOWS-1:0] mem_claim
);
  logic [7:0] en;
  logic [7:0] ctl;
  logic [3:0] nib;
  // Shadows follow host writes so expectations never come from the design
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h06) begin
      en <= reg_wdata;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h07) begin
      ctl <= reg_wdata;
    end
  end
  assign nib = io_window ? ctl[7:4] : ctl[3:0];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence short_run; ##15 io_done; endsequence
  sequence wait_run; ##20 io_done; endsequence
  sequence long_run; ##30 io_done; endsequence
  narrow_std_len_a:
    assert property (io_claim && !io_wide && !nib[2] |-> long_run) else $error("narrow len");
  narrow_short_len_a:
    assert property (io_claim && !io_wide && nib[2] |-> short_run) else $error("short len");
  wide_std_len_a:
    assert property (io_claim && io_wide && !nib[3] |-> short_run) else $error("wide len");
  wide_wait_len_a:
    assert property (io_claim && io_wide && nib[3] |-> wait_run) else $error("wait len");
  fixed_width_a:
    assert property (io_claim && !nib[1] |-> io_wide == nib[0]) else $error("fixed width");
  card_width_a:
    assert property (io_claim && nib[1] |-> io_wide == card_iois16) else $error("card width");
  claim_enabled_a:
    assert property (io_claim |-> $past(io_req) && !$past(io_busy)
      && (io_window ? $past(en[7]) : $past(en[6]))) else $error("bad claim");
  busy_span_a:
    assert property (io_done |-> io_busy ##1 !io_busy) else $error("busy span");
  mem_gate_a:
    assert property (mem_claim == ($past(mem_req) ? $past(mem_hit) & $past(en[4:0]) : 5'h00))
      else $error("mem claim");
  enable_read_a:
    assert property (reg_rd && reg_addr == 8'h06 |=> reg_rdata == ($past(en) & 8'hDF))
      else $error("enable read");
endmodule
bind card_window_enable_io_control card_window_properties card_window_properties_i (.clk, .rst,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .io_req, .card_iois16, .io_claim,
  .io_window, .io_wide, .io_busy, .io_done, .mem_req, .mem_hit, .mem_claim);

// file: tb/pc_card_model.sv
`timescale 1ns/100ps
module pc_card_model (
  input wire logic clk,
  input wire logic card_wide,
  output logic card_iois16
);
  // The card reports its own port width; the bench picks which kind of port is hit
  always_ff @(posedge clk) begin
    card_iois16 <= card_wide;
  end
endmodule
